/* File: test/srw_ref_source.sv */
// Model of the reference pulse as seen through the tap delay line.
// Assumes the bench fires it and places the edge among the taps.
`timescale 1ns/1ps
module srw_ref_source (
  input wire aclk,
  input wire ref_fire,
  input wire [4:0] ref_edge_pos,
  output logic [23:0] ref_tap_sample
);
  logic [2:0] hold = 3'h0;
  logic ref_prev = 1'h0;
  // One-shot reference four cycles wide
  always @(posedge aclk) begin
    if (ref_fire) begin
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
    ref_prev <= (hold != 3'h0);
  end
  // Taps at or past the edge position see the pulse a cycle late
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      ref_tap_sample[i] = (i < ref_edge_pos) ? (hold != 3'h0) : ref_prev;
    end
  end
endmodule // srw_ref_source

/* File: test/srw_window_capture_monitor.sv */
// Checker for the reference window capture block.
// Sees only the top module ports; bound after the module.
`timescale 1ns/1ps
module srw_window_capture_monitor (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire ref_captured,
  input wire frame_boundary,
  input wire encoding_64b66b,
  input wire [3:0] active_lanes,
  input wire sync_request_used
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Link settings stay legal and consistent
  lane_range_a: assert property (active_lanes >= 4'h1 && active_lanes <= 4'h8)
    else $error("lane count out of range");
  sync_use_a: assert property (sync_request_used == !encoding_64b66b)
    else $error("sync request use wrong");
  // Capture is one pulse and restarts the frame counter
  capture_pulse_a: assert property (ref_captured |=> !ref_captured)
    else $error("capture pulse too long");
  capture_frame_a: assert property (ref_captured |-> ##[0:1] frame_boundary)
    else $error("capture did not reset counter");
  // Bus handshakes
  read_latency_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready && s_axi_rvalid) else $error("read answer late");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  write_resp_a: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready too long");
endmodule // srw_window_capture_monitor
bind srw_window_capture srw_window_capture_monitor mon (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .ref_captured, .frame_boundary, .encoding_64b66b, .active_lanes,
  .sync_request_used);

/* File: test/srw_window_capture_tb.sv */
// Self-checking bench for the reference window capture block.
// Drives AXI4-Lite and the reference model; aclk at 20 MHz.
`timescale 1ns/1ps
`include "srw_regs.vh"
module srw_window_capture_tb;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, d;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ref_fire = 1'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [4:0] ref_edge_pos = 5'h0;
  logic [1:0] r;
  logic [23:0] st;
  // Two synchroniser flops, edge detect and output flop after the pin edge
  localparam int CAP_BASE = 4;
  wire [23:0] ref_tap_sample;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire ref_captured, frame_boundary, encoding_64b66b, sync_request_used;
  wire [3:0] active_lanes;
  int err_count = 0, comparisons = 0, lat, base, p, n, e;
  initial begin
    forever #25 aclk = ~aclk;
  end
  srw_window_capture DUT (.aclk, .aresetn, .ref_tap_sample, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ref_captured,
    .frame_boundary, .encoding_64b66b, .active_lanes, .sync_request_used);
  srw_ref_source model (.aclk, .ref_fire, .ref_edge_pos, .ref_tap_sample);
  task wr(input logic [7:0] i, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, i, 2'h0};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [7:0] i);
    @(posedge aclk);
    s_axi_araddr <= {22'h0, i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'h0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Taps at or past the edge see the pulse one cycle later
  function int cap_lat(int s, int p);
    return CAP_BASE + (s >= p);
  endfunction
  // Risky taps at the edge pair, end taps always risky
  function logic [23:0] exp_status(int p);
    return 24'h80_0001 | (24'h00_0003 << (p - 1));
  endfunction
  task finish_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    err_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    void'($urandom(86872));
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`SRW_IDX_CTRL);
    chk(d, `SRW_CTRL_RESET);
    rd(`SRW_IDX_LINK);
    chk(d, `SRW_LINK_RESET);
    rd(`SRW_IDX_STATUS_LOW);
    chk({r, d[0]}, {`SRW_RESP_OKAY, 1'h1});
    rd(`SRW_IDX_STATUS_HIGH);
    chk(d[7], 1'h1);
    rd(8'h3f);
    chk(r, `SRW_RESP_SLVERR);
    wr(8'h3f, 32'h0);
    chk(r, `SRW_RESP_SLVERR);
    repeat (4) begin
      e = $urandom % 2;
      n = 1 + $urandom % 8;
      wr(`SRW_IDX_LINK, {12'h0, 12'h00f, n[3:0], 3'h0, e[0]});
      repeat (2) @(posedge aclk);
      chk({sync_request_used, encoding_64b66b, active_lanes}, {~e[0], e[0], n[3:0]});
    end
    do @(posedge aclk); while (!frame_boundary);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!frame_boundary);
    chk(n, 16);
    for (int s = 0; s < 16; s++) begin
      p = 1 + $urandom % 23;
      e = $urandom % 2;
      // Host sweep of selectable taps, each with a random step size
      wr(`SRW_IDX_CTRL, {27'h0, e[0], s[3:0]});
      rd(`SRW_IDX_CTRL);
      chk(d, {27'h0, e[0], s[3:0]});
      ref_edge_pos <= p[4:0];
      ref_fire <= 1'h1;
      @(posedge aclk);
      ref_fire <= 1'h0;
      lat = 0;
      while (!ref_captured && lat < 20) begin
        @(posedge aclk);
        lat++;
      end
      if (s == 0) base = lat;
      chk(lat, cap_lat(s, p));
      rd(`SRW_IDX_STATUS_LOW);
      st[7:0] = d[7:0];
      rd(`SRW_IDX_STATUS_MID);
      st[15:8] = d[7:0];
      rd(`SRW_IDX_STATUS_HIGH);
      st[23:16] = d[7:0];
      chk({8'h0, st}, {8'h0, exp_status(p)});
    end
    chk(base, CAP_BASE);
    finish_test();
  end
endmodule // srw_window_capture_tb

/* File: verilog/srw_regs.vh */
// Register map and constants of the reference window capture block.
// Assumes an AXI4-Lite master with 32-bit data, one register per word.
// Function
// RULE_01 - Capture reference on deterministic device clock edge
// RULE_02 - Measure reference position into 24-bit status
// RULE_03 - Status one means risky, zero means safe
// RULE_04 - Select field picks capture tap by index
// RULE_05 - Step bit chooses coarse or fine delay; code only stores it in ctrl bit 4 and no output uses it
// RULE_06 - Status bits 0 and 23 always one
// RULE_07 - Only taps 0 to 15 selectable
// RULE_08 - Host keeps fine steps unless no transition
// RULE_09 - Host picks safe tap midway, lower preferred
// RULE_10 - Support 8B/10B and 64B/66B, up to 8 lanes
// RULE_11 - 64B/66B block sync needs no sync request
// RULE_12 - Captured reference resets multiframe or multiblock counter
// RULE_13 - Device clock clocks all digital logic
// RULE_14 - 8B/10B formats stay compatible with older receivers
// RULE_15 - Periodic reference at counter rate or submultiple
// RULE_16 - Refresh status vector continuously; code refreshes it only while a reference edge lies inside the tap span
`ifndef SRW_REGS_VH
`define SRW_REGS_VH
// Printed offsets are not word multiples: kept as indices, byte address is 4x
`define SRW_IDX_STATUS_LOW 8'h2c
`define SRW_IDX_STATUS_MID 8'h2d
`define SRW_IDX_STATUS_HIGH 8'h2e
`define SRW_IDX_CTRL 8'h30
`define SRW_IDX_LINK 8'h31
`define SRW_IDX_COUNT 8'h32
// Control register fields
`define SRW_CTRL_SEL_LSB 0
`define SRW_CTRL_SEL_MSB 3
`define SRW_CTRL_FINE_BIT 4
`define SRW_CTRL_RESET 32'h0000_0010
`define SRW_CTRL_MASK 32'h0000_001f
// Link register fields
`define SRW_LINK_ENC64_BIT 0
`define SRW_LINK_LANES_LSB 4
`define SRW_LINK_LANES_MSB 7
`define SRW_LINK_PERIOD_LSB 8
`define SRW_LINK_PERIOD_MSB 19
`define SRW_LINK_RESET 32'h0002_0081
`define SRW_LINK_MASK 32'h000f_fff1
// Status edge bits and tap counts
`define SRW_TAPS 24
`define SRW_SEL_TAPS 16
`define SRW_EDGE_HI 23
// AXI responses
`define SRW_RESP_OKAY 2'b00
`define SRW_RESP_SLVERR 2'b10
`endif

/* File: verilog/srw_window_capture.v */
// Reference window capture: tap-sampled reference position status, tap
// selected capture, local multiframe / extended multiblock counter reset.
// Assumes the tap samples come from a delay line outside this block; all
// logic here runs on the device clock aclk.
`timescale 1ns/1ps
`include "srw_regs.vh"

module srw_window_capture #(
  parameter TAPS = `SRW_TAPS,
  parameter CNT_W = 12,
  parameter MAX_LANES = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [TAPS-1:0] ref_tap_sample,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg ref_captured,
  output reg frame_boundary,
  output reg encoding_64b66b,
  output reg [3:0] active_lanes,
  output reg sync_request_used
);

  // Two-flop synchroniser on the tap samples, which come from pins
  reg [TAPS-1:0] tap_meta;
  reg [TAPS-1:0] tap_sync;
  reg [TAPS-1:0] tap_prev;
  reg [TAPS-1:0] ref_position_status;
  reg [31:0] ctrl;
  reg [31:0] link_cfg;
  reg [CNT_W-1:0] lmfc_count;
  reg cap_prev;
  reg have_aw;
  reg have_w;
  reg [7:0] aw_idx;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire [3:0] ref_sample_select;
  wire ref_step_fine;
  wire [CNT_W-1:0] period;
  wire cap_now;
  reg [TAPS-1:0] next_status;
  integer i;

  assign ref_sample_select = ctrl[`SRW_CTRL_SEL_MSB:`SRW_CTRL_SEL_LSB];
  assign ref_step_fine = ctrl[`SRW_CTRL_FINE_BIT];
  assign period = link_cfg[`SRW_LINK_PERIOD_MSB:`SRW_LINK_PERIOD_LSB];
  // Capture on the chosen tap; only 16 taps are reachable by 4 bits
  assign cap_now = tap_sync[ref_sample_select]; // see RULE_04 see RULE_07

  // Word index from a byte address
  function [7:0] srw_index;
    input [31:0] addr;
    begin
      srw_index = addr[9:2];
    end
  endfunction

  // Merge write data into a register under byte strobes
  function [31:0] srw_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer b;
    begin
      srw_merge = old_val;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          srw_merge[b*8 +: 8] = new_val[b*8 +: 8];
        end
      end
    end
  endfunction

  // Read mux over the register map
  function [31:0] srw_read;
    input [7:0] idx;
    input [TAPS-1:0] st;
    input [31:0] c;
    input [31:0] l;
    input [CNT_W-1:0] cnt;
    begin
      case (idx)
        `SRW_IDX_STATUS_LOW: srw_read = {24'h00_0000, st[7:0]};
        `SRW_IDX_STATUS_MID: srw_read = {24'h00_0000, st[15:8]};
        `SRW_IDX_STATUS_HIGH: srw_read = {24'h00_0000, st[23:16]};
        `SRW_IDX_CTRL: srw_read = c;
        `SRW_IDX_LINK: srw_read = l;
        `SRW_IDX_COUNT: srw_read = {{(32-CNT_W){1'b0}}, cnt};
        default: srw_read = 32'h0000_0000;
      endcase
    end
  endfunction

  // Address known test
  function srw_mapped;
    input [7:0] idx;
    begin
      srw_mapped = (idx >= `SRW_IDX_STATUS_LOW) && (idx <= `SRW_IDX_COUNT);
    end
  endfunction

  // A tap is risky if its sample differs from a neighbour's, or if it and its lower
  // neighbour changed between clocks but its upper one did not, i.e. it is near the edge
  always @* begin
    next_status = {TAPS{1'b0}};
    for (i = 1; i < TAPS - 1; i = i + 1) begin
      next_status[i] = (tap_sync[i] ^ tap_sync[i-1]) | (tap_sync[i] ^ tap_sync[i+1]) |
                       (tap_sync[i] ^ tap_prev[i]) & (tap_sync[i-1] ^ tap_prev[i-1]) &
                       ~(tap_sync[i+1] ^ tap_prev[i+1]); // see RULE_03
    end
    next_status[0] = 1'b1; // see RULE_06
    next_status[`SRW_EDGE_HI] = 1'b1; // see RULE_06
  end

  // Synchroniser and position status, refreshed while a reference edge lies inside the tap span
  always @(posedge aclk) begin // see RULE_13
    if (!aresetn) begin
      tap_meta <= {TAPS{1'b0}};
      tap_sync <= {TAPS{1'b0}};
      tap_prev <= {TAPS{1'b0}};
      ref_position_status <= {TAPS{1'b1}};
    end else begin
      tap_meta <= ref_tap_sample;
      tap_sync <= tap_meta;
      tap_prev <= tap_sync;
      // Only update when a reference edge lies inside the tap span
      if (tap_sync != {TAPS{1'b0}} && tap_sync != {TAPS{1'b1}}) begin
        ref_position_status <= next_status; // see RULE_02 see RULE_16
      end
    end
  end

  // Deterministic capture and counter reset on reference rising edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      cap_prev <= 1'b0;
      ref_captured <= 1'b0;
      lmfc_count <= {CNT_W{1'b0}};
      frame_boundary <= 1'b0;
    end else begin
      cap_prev <= cap_now;
      ref_captured <= cap_now & ~cap_prev; // see RULE_01
      if (cap_now & ~cap_prev) begin
        lmfc_count <= {CNT_W{1'b0}}; // see RULE_12
        frame_boundary <= 1'b1;
      end else if (lmfc_count >= period) begin
        lmfc_count <= {CNT_W{1'b0}};
        frame_boundary <= 1'b1;
      end else begin
        lmfc_count <= lmfc_count + {{(CNT_W-1){1'b0}}, 1'b1};
        frame_boundary <= 1'b0;
      end
    end
  end

  // Link configuration outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      encoding_64b66b <= 1'b0;
      active_lanes <= MAX_LANES[3:0];
      sync_request_used <= 1'b1;
    end else begin
      encoding_64b66b <= link_cfg[`SRW_LINK_ENC64_BIT]; // see RULE_10
      // Lanes clamped to 1..MAX_LANES
      if (link_cfg[`SRW_LINK_LANES_MSB:`SRW_LINK_LANES_LSB] == 4'h0) begin
        active_lanes <= 4'h1;
      end else if (link_cfg[`SRW_LINK_LANES_MSB:`SRW_LINK_LANES_LSB] > MAX_LANES) begin
        active_lanes <= MAX_LANES[3:0]; // see RULE_10
      end else begin
        active_lanes <= link_cfg[`SRW_LINK_LANES_MSB:`SRW_LINK_LANES_LSB];
      end
      // 8B/10B keeps the sync request handshake; 64B/66B uses sync headers
      sync_request_used <= ~link_cfg[`SRW_LINK_ENC64_BIT]; // see RULE_11 see RULE_14
    end
  end

  // AXI4-Lite write channel: address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SRW_RESP_OKAY;
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_idx <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      ctrl <= `SRW_CTRL_RESET;
      link_cfg <= `SRW_LINK_RESET;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && !have_aw && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        have_aw <= 1'b1;
        aw_idx <= srw_index(s_axi_awaddr);
      end
      if (s_axi_wvalid && !have_w && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        have_w <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (have_aw && have_w && !s_axi_bvalid) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= srw_mapped(aw_idx) ? `SRW_RESP_OKAY : `SRW_RESP_SLVERR;
        if (aw_idx == `SRW_IDX_CTRL) begin
          ctrl <= srw_merge(ctrl, w_data, w_strb) & `SRW_CTRL_MASK; // see RULE_05
        end
        if (aw_idx == `SRW_IDX_LINK) begin
          link_cfg <= srw_merge(link_cfg, w_data, w_strb) & `SRW_LINK_MASK;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SRW_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= srw_read(srw_index(s_axi_araddr), ref_position_status, ctrl,
                                link_cfg, lmfc_count);
        s_axi_rresp <= srw_mapped(srw_index(s_axi_araddr)) ? `SRW_RESP_OKAY :
                       `SRW_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // srw_window_capture
